// ==== dbgcs_pkg.sv ====
// dbgcs_pkg: shared constants, command codes and types for the debug
// settings, status and code-trap block.
// assumes: byte-wide debug commands delivered by a serial front end.
package dbgcs_pkg;

    // =====================================================================
    // command codes
    localparam logic [7:0] OP_WR_SETTINGS = 8'h19;
    localparam logic [7:0] OP_RD_SETTINGS = 8'h24;
    localparam logic [7:0] OP_RD_FLAGS    = 8'h30;
    localparam logic [7:0] OP_SET_TRAP    = 8'h3f;
    localparam logic [7:0] OP_HALT        = 8'h44;
    localparam logic [7:0] OP_RESUME      = 8'h4c;
    localparam logic [5:0] OP_INJECT_HI   = 6'h15;
    localparam logic [5:0] OP_STEP_REP_HI = 6'h19;

    // =====================================================================
    // settings byte fields
    localparam int SET_TIMER_STOP   = 3;
    localparam int SET_DMA_HOLD     = 2;
    localparam int SET_TIMER_FREEZE = 1;
    localparam int SET_INFO_REGION  = 0;
    localparam int SET_W            = 4;
    localparam logic [SET_W-1:0] SETTINGS_RST = 4'h0;

    // =====================================================================
    // flags byte fields
    localparam int FLG_ERASE_DONE = 7;
    localparam int FLG_CLK_GATED  = 6;
    localparam int FLG_HALTED     = 5;
    localparam int FLG_ACTIVE_PM  = 4;
    localparam int FLG_HALT_CAUSE = 3;
    localparam int FLG_LOCKED     = 2;
    localparam int FLG_OSC_STABLE = 1;
    localparam int FLG_STACK_OVF  = 0;

    localparam logic [7:0] STACK_TOP_ADDR = 8'hff;
    localparam logic [1:0] PM_ACTIVE      = 2'h0;
    localparam int TRAP_SLOTS  = 4;
    localparam int TRAP_ADDR_W = 18;

    typedef enum logic [1:0] {
        LNK_OPCODE = 2'b00,
        LNK_DATA   = 2'b01,
        LNK_WAIT   = 2'b10
    } dbgcs_lnk_state_t;

    // one whole command, held stable while it crosses to the core side
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] d2;
    } dbgcs_cmd_t;

    function automatic logic [1:0] data_len(input logic [7:0] op);
        if (op == OP_WR_SETTINGS) return 2'h1;
        if (op == OP_SET_TRAP) return 2'h3;
        if (op[7:2] == OP_INJECT_HI || op[7:2] == OP_STEP_REP_HI) return op[1:0];
        return 2'h0;
    endfunction

    function automatic logic needs_reply(input logic [7:0] op);
        return (op == OP_RD_SETTINGS) || (op == OP_RD_FLAGS);
    endfunction

endpackage

// ==== dbgcs_top.sv ====
// dbgcs_top: debug settings byte, status flags byte, four code traps and
// halt/resume control, fed with command bytes from the debug link.
// assumes: link bytes arrive framed on link_clk; cpu side signals are on
// core_clk; serial timing, flash and power sequencing live elsewhere.
`timescale 1ns/1ps

module dbgcs_top (
    input  wire logic                            core_clk,          // system clock, 25 MHz
    input  wire logic                            rst,               // sync reset, active high
    input  wire logic                            link_clk,          // debug link clock
    input  wire logic [7:0]                      link_byte,         // received command/data byte
    input  wire logic                            link_byte_valid,   // byte strobe, link_clk
    output logic      [7:0]                      link_reply_q,      // reply byte
    output logic                                 link_reply_valid_q,// reply strobe, link_clk
    input  wire logic [dbgcs_pkg::TRAP_ADDR_W-1:0] cpu_code_addr,   // cpu code address bus
    input  wire logic                            cpu_clock_gated,   // cpu idle, clock gated
    input  wire logic [1:0]                      power_mode,        // selected power mode 0..3
    input  wire logic                            sleep_wake,        // wake from sleep, pulse
    input  wire logic                            erase_busy,        // mass erase in progress
    input  wire logic                            debugger_lockout,  // stored lockout bit
    input  wire logic                            xosc_stable,       // crystal osc stable
    input  wire logic                            hfrc_stable,       // hf rc osc stable
    input  wire logic                            data_wr,           // cpu data memory write
    input  wire logic [7:0]                      data_wr_addr,      // its internal address
    input  wire logic                            inject_opcode,     // injected opcode running
    input  wire logic                            step_branch,       // stepped branch running
    input  wire logic                            debug_active,      // debugger attached
    output logic                                 timer_run_q,       // timers may count
    output logic                                 dma_hold_q,        // pause all dma
    output logic                                 info_region_select,// flash info page select
    output logic                                 cpu_halt_q,        // stop the cpu
    output logic                                 regulator_hold_q   // keep core regulator on
);

    // =====================================================================
    // link side: reset sync, ack sync and command framing
    logic                        lrst1_q, lrst2_q;
    logic                        la1_q, la2_q, la3_q;
    logic                        req_tgl_q;
    logic                        ack_tgl_q;
    logic [1:0]                  left_q;
    dbgcs_pkg::dbgcs_lnk_state_t lst_q;
    dbgcs_pkg::dbgcs_cmd_t       lcmd_q;
    logic [7:0]                  reply_q;

    wire       ack_seen  = la2_q ^ la3_q;
    wire [1:0] byte_need = dbgcs_pkg::data_len(link_byte);
    // slot of the next data byte within the command, counted from d0
    wire [1:0] data_pos  = dbgcs_pkg::data_len(lcmd_q.op) - left_q;

    always_ff @(posedge link_clk) begin
        lrst1_q <= rst;
        lrst2_q <= lrst1_q;
        la1_q   <= ack_tgl_q;
        la2_q   <= la1_q;
        la3_q   <= la2_q;
    end

    // bytes that arrive while a command is crossing are dropped; the host
    // waits for a reply or a fixed gap after each command, so no buffer is kept here
    always_ff @(posedge link_clk) begin
        link_reply_valid_q <= 1'b0;
        if (lrst2_q) begin
            lst_q        <= dbgcs_pkg::LNK_OPCODE;
            req_tgl_q    <= 1'b0;
            left_q       <= 2'h0;
            lcmd_q       <= '0;
            link_reply_q <= 8'h00;
        end else begin
            case (lst_q)
                dbgcs_pkg::LNK_OPCODE: begin
                    if (link_byte_valid) begin
                        lcmd_q <= '{op: link_byte, d0: 8'h00, d1: 8'h00, d2: 8'h00};
                        left_q <= byte_need;
                        if (byte_need == 2'h0) begin
                            req_tgl_q <= ~req_tgl_q;
                            lst_q     <= dbgcs_pkg::LNK_WAIT;
                        end else begin
                            lst_q <= dbgcs_pkg::LNK_DATA;
                        end
                    end
                end
                dbgcs_pkg::LNK_DATA: begin
                    if (link_byte_valid) begin
                        // data bytes fill d0, d1, d2 in arrival order
                        case (data_pos)
                            2'h0:    lcmd_q.d0 <= link_byte;
                            2'h1:    lcmd_q.d1 <= link_byte;
                            default: lcmd_q.d2 <= link_byte;
                        endcase
                        left_q <= left_q - 2'h1;
                        if (left_q == 2'h1) begin
                            req_tgl_q <= ~req_tgl_q;
                            lst_q     <= dbgcs_pkg::LNK_WAIT;
                        end
                    end
                end
                dbgcs_pkg::LNK_WAIT: begin
                    if (ack_seen) begin
                        link_reply_valid_q <= dbgcs_pkg::needs_reply(lcmd_q.op);
                        link_reply_q       <= reply_q;
                        lst_q              <= dbgcs_pkg::LNK_OPCODE;
                    end
                end
                default: lst_q <= dbgcs_pkg::LNK_OPCODE;
            endcase
        end
    end

    // =====================================================================
    // core side: request sync and command execution strobes
    logic cr1_q, cr2_q, cr3_q;
    always_ff @(posedge core_clk) begin
        cr1_q <= req_tgl_q;
        cr2_q <= cr1_q;
        cr3_q <= cr2_q;
    end

    // lcmd_q is held still from the toggle until the ack returns
    wire       exec      = cr2_q ^ cr3_q;
    wire [7:0] op        = lcmd_q.op;
    wire       do_wr_set = exec && op == dbgcs_pkg::OP_WR_SETTINGS;
    wire       do_halt   = exec && op == dbgcs_pkg::OP_HALT;
    wire       do_resume = exec && op == dbgcs_pkg::OP_RESUME;
    wire       do_trap   = exec && op == dbgcs_pkg::OP_SET_TRAP;
    wire [1:0] trap_slot = lcmd_q.d0[4:3];
    wire       trap_on   = lcmd_q.d0[2];
    wire [dbgcs_pkg::TRAP_ADDR_W-1:0] trap_addr = {lcmd_q.d0[1:0], lcmd_q.d1, lcmd_q.d2};

    // =====================================================================
    // settings byte
    logic [dbgcs_pkg::SET_W-1:0] settings_q;
    always_ff @(posedge core_clk) begin
        if (rst)
            settings_q <= dbgcs_pkg::SETTINGS_RST;
        else if (do_wr_set)
            settings_q <= lcmd_q.d0[dbgcs_pkg::SET_W-1:0];
    end

    wire stop_bit   = settings_q[dbgcs_pkg::SET_TIMER_STOP];
    wire freeze_bit = settings_q[dbgcs_pkg::SET_TIMER_FREEZE];
    wire frozen     = freeze_bit && (inject_opcode || step_branch);
    wire timer_d    = !(stop_bit || frozen);

    // =====================================================================
    // code traps
    logic [dbgcs_pkg::TRAP_ADDR_W-1:0] trap_addr_q [dbgcs_pkg::TRAP_SLOTS];
    logic [dbgcs_pkg::TRAP_SLOTS-1:0]  trap_en_q;
    logic [dbgcs_pkg::TRAP_SLOTS-1:0]  slot_hit;

    for (genvar i = 0; i < dbgcs_pkg::TRAP_SLOTS; i++) begin : g_slot
        assign slot_hit[i] = trap_en_q[i] && trap_addr_q[i] == cpu_code_addr;
        always_ff @(posedge core_clk) begin
            if (rst) begin
                trap_en_q[i]   <= 1'b0;
                trap_addr_q[i] <= '0;
            end else if (do_trap && trap_slot == 2'(i)) begin
                trap_en_q[i]   <= trap_on;
                trap_addr_q[i] <= trap_addr;
            end
        end
    end

    wire trap_hit = |slot_hit;

    // =====================================================================
    // halt control
    logic halted_q, cause_q, stall_q, ovf_q;
    logic halted_d, cause_d, stall_d;

    // halt command wins over a trap in the same cycle; resume needs halted
    assign halted_d = do_halt ? 1'b1 : (trap_hit && !halted_q) ? 1'b1 :
                      (do_resume && halted_q) ? 1'b0 : halted_q;
    assign cause_d  = do_halt ? 1'b0 : (trap_hit && !halted_q) ? 1'b1 : cause_q;
    // deep sleep wake freezes the cpu until halt then resume
    wire   deep_wake = sleep_wake && debug_active && power_mode[1];
    assign stall_d  = deep_wake ? 1'b1 : (do_resume && halted_q) ? 1'b0 : stall_q;

    wire ovf_set = data_wr && data_wr_addr == dbgcs_pkg::STACK_TOP_ADDR;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            halted_q <= 1'b0;
            cause_q  <= 1'b0;
            stall_q  <= 1'b0;
            ovf_q    <= 1'b0;
        end else begin
            halted_q <= halted_d;
            cause_q  <= cause_d;
            stall_q  <= stall_d;
            ovf_q    <= ovf_q | ovf_set;
        end
    end

    // =====================================================================
    // flags byte, sampled live when the reply is latched
    logic [7:0] flags;
    always_comb begin
        flags = 8'h00;
        flags[dbgcs_pkg::FLG_ERASE_DONE] = !erase_busy;
        flags[dbgcs_pkg::FLG_CLK_GATED]  = cpu_clock_gated;
        flags[dbgcs_pkg::FLG_HALTED]     = halted_q;
        flags[dbgcs_pkg::FLG_ACTIVE_PM]  = power_mode == dbgcs_pkg::PM_ACTIVE;
        flags[dbgcs_pkg::FLG_HALT_CAUSE] = cause_q;
        flags[dbgcs_pkg::FLG_LOCKED]     = debugger_lockout;
        flags[dbgcs_pkg::FLG_OSC_STABLE] = xosc_stable && hfrc_stable;
        flags[dbgcs_pkg::FLG_STACK_OVF]  = ovf_q;
    end

    wire [7:0] reply_d = (op == dbgcs_pkg::OP_RD_FLAGS) ? flags
                       : {4'h0, settings_q};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_tgl_q <= 1'b0;
            reply_q   <= 8'h00;
        end else if (exec) begin
            ack_tgl_q <= ~ack_tgl_q;
            reply_q   <= reply_d;
        end
    end

    // =====================================================================
    // outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_run_q        <= 1'b1;
            dma_hold_q         <= 1'b0;
            info_region_select <= 1'b0;
            cpu_halt_q         <= 1'b0;
            regulator_hold_q   <= 1'b0;
        end else begin
            timer_run_q        <= timer_d;
            dma_hold_q         <= settings_q[dbgcs_pkg::SET_DMA_HOLD];
            info_region_select <= settings_q[dbgcs_pkg::SET_INFO_REGION];
            cpu_halt_q         <= halted_d | stall_d;
            regulator_hold_q   <= debug_active;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // timer, dma and info region controls follow the settings byte one cycle late; regulator hold follows debug_active
    a_timer_stop_bit: assert property (
        stop_bit |=> !timer_run_q)
        else $error("timers ran with stop bit set");
    a_timer_freeze_inj: assert property (
        freeze_bit && inject_opcode |=> !timer_run_q)
        else $error("timers ran during injected opcode");
    a_timer_freeze_br: assert property (
        freeze_bit && step_branch |=> !timer_run_q)
        else $error("timers ran during stepped branch");
    a_dma_hold_follow: assert property (
        ##1 dma_hold_q == $past(settings_q[dbgcs_pkg::SET_DMA_HOLD]))
        else $error("dma hold does not follow settings");
    a_info_region_follow: assert property (
        ##1 info_region_select == $past(settings_q[dbgcs_pkg::SET_INFO_REGION]))
        else $error("info region select does not follow settings");
    a_regulator_hold: assert property (
        ##1 regulator_hold_q == $past(debug_active))
        else $error("core regulator hold does not follow debug state");

    // halt, resume and wake handling
    a_halt_cmd_cause: assert property (
        do_halt |=> halted_q && !cause_q && cpu_halt_q)
        else $error("halt command not recorded");
    a_trap_halts_cpu: assert property (
        trap_hit && !halted_q && !do_halt |=> halted_q && cause_q)
        else $error("trap match did not halt with trap cause");
    a_resume_runs: assert property (
        do_resume && halted_q && !stall_q && !deep_wake |=> !halted_q && !cpu_halt_q)
        else $error("resume did not release cpu");
    a_resume_idle: assert property (
        do_resume && !halted_q && !trap_hit |=> !halted_q)
        else $error("resume while running changed halt state");
    a_deep_wake_stall: assert property (
        deep_wake |=> stall_q && cpu_halt_q)
        else $error("deep sleep wake did not stop the cpu");
    a_light_wake_runs: assert property (
        sleep_wake && !power_mode[1] && !halted_q && !stall_q && !trap_hit && !do_halt
        |=> !cpu_halt_q)
        else $error("sleep level one wake stopped the cpu");

    // code traps
    a_slot_zero_kept: assert property (
        do_trap && trap_slot != 2'h0 |=> $stable(trap_addr_q[0]) && $stable(trap_en_q[0]))
        else $error("unselected trap slot changed");
    a_trap_slot_load: assert property (
        do_trap |=> trap_en_q[$past(trap_slot)] == $past(trap_on)
            && trap_addr_q[$past(trap_slot)] == $past(trap_addr))
        else $error("selected trap slot not loaded");

    // flags, replies and the crossing handshake
    a_stack_ovf_sticky: assert property (
        ovf_set |=> ovf_q [*3])
        else $error("stack overflow flag lost");
    a_flags_reply: assert property (
        exec && op == dbgcs_pkg::OP_RD_FLAGS
        |=> reply_q[dbgcs_pkg::FLG_OSC_STABLE] == ($past(xosc_stable) && $past(hfrc_stable))
            && reply_q[dbgcs_pkg::FLG_ERASE_DONE] == !$past(erase_busy))
        else $error("flags reply not sampled live");
    a_flags_mode: assert property (
        exec && op == dbgcs_pkg::OP_RD_FLAGS
        |=> reply_q[dbgcs_pkg::FLG_ACTIVE_PM] == ($past(power_mode) == dbgcs_pkg::PM_ACTIVE)
            && reply_q[dbgcs_pkg::FLG_LOCKED] == $past(debugger_lockout))
        else $error("flags reply mode or lock bit wrong");
    a_settings_reply: assert property (
        exec && op == dbgcs_pkg::OP_RD_SETTINGS
        |=> reply_q == {4'h0, $past(settings_q)})
        else $error("settings reply differs from settings");
    a_ack_per_exec: assert property (
        exec |=> ack_tgl_q != $past(ack_tgl_q))
        else $error("executed command not acknowledged");

    c_halt_cmd:  cover property (do_halt ##[1:400] do_resume);
    c_trap_hit:  cover property (trap_hit && !halted_q);
    c_read_flag: cover property (exec && op == dbgcs_pkg::OP_RD_FLAGS);
    c_deep_wake: cover property (deep_wake ##[1:50] do_halt);
    c_trap_load: cover property (do_trap && trap_on);

endmodule

// ==== dbgcs_host.sv ====
// dbgcs_host: behavioural debug host that frames command bytes on the link.
// assumes: link_clk is made by the bench; the device takes one byte per strobe.
`timescale 1ns/1ps
module dbgcs_host (
    input  wire logic       link_clk,          // debug link clock
    output logic      [7:0] link_byte,         // byte to the device
    output logic            link_byte_valid,   // byte strobe
    input  wire logic [7:0] link_reply_q,      // reply byte
    input  wire logic       link_reply_valid_q // reply strobe
);
    initial begin
        link_byte       = 8'h00;
        link_byte_valid = 1'b0;
    end

    // ======================================================================
    // command framing
    task automatic put_byte(input logic [7:0] b);
        @(negedge link_clk);
        link_byte       = b;
        link_byte_valid = 1'b1;
    endtask

    // opcode, then exactly n data bytes with d0 first; optional reply wait
    task automatic cmd(input logic [7:0] op, input int n, input logic [23:0] d,
                       input bit want, output logic [7:0] reply);
        int k;
        reply = 8'hxx;
        put_byte(op);
        for (k = 0; k < n; k++) put_byte(d[23-8*k -: 8]);
        @(negedge link_clk);
        link_byte_valid = 1'b0;
        link_byte       = ~link_byte; // released byte lane shows no stale value
        for (k = 0; k < 20 && want; k++) begin
            @(negedge link_clk);
            if (link_reply_valid_q === 1'b1) begin
                reply = link_reply_q;
                break;
            end
        end
        repeat (want ? 2 : 12) @(posedge link_clk);
    endtask
endmodule

// ==== debug_config_status_breakpoint_tb_top.sv ====
// testbench: drives the debug block through the host model and checks it
// against a small behavioural model. assumes dbgcs_pkg and dbgcs_top.
`timescale 1ns/1ps
module debug_config_status_breakpoint_tb_top;
    logic core_clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
    logic [7:0] link_byte, link_reply_q, data_wr_addr = 8'h00, r;
    logic link_byte_valid, link_reply_valid_q, timer_run_q, dma_hold_q;
    logic info_region_select, cpu_halt_q, regulator_hold_q;
    logic [17:0] cpu_code_addr = 18'h0;
    logic [1:0] power_mode = 2'h0;
    logic cpu_clock_gated = 0, sleep_wake = 0, erase_busy = 0, debugger_lockout = 0;
    logic xosc_stable = 1, hfrc_stable = 1, data_wr = 0, inject_opcode = 0;
    logic step_branch = 0, debug_active = 0;
    int bad_count = 0, check_count = 0, seed = 53, i, j;
    logic [31:0] rv;
    logic [3:0] set_m = 4'h0;
    logic halted_m = 0, cause_m = 0, ovf_m = 0;
    logic [17:0] tr_a [4];
    logic tr_e [4] = '{0, 0, 0, 0};

    initial forever #20 core_clk = ~core_clk;
    initial begin
        #7;
        forever #62.5 link_clk = ~link_clk;
    end

    dbgcs_host host (.link_clk(link_clk), .link_byte(link_byte),
        .link_byte_valid(link_byte_valid), .link_reply_q(link_reply_q),
        .link_reply_valid_q(link_reply_valid_q));

    dbgcs_top DUT (.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
        .link_byte(link_byte), .link_byte_valid(link_byte_valid),
        .link_reply_q(link_reply_q), .link_reply_valid_q(link_reply_valid_q),
        .cpu_code_addr(cpu_code_addr), .cpu_clock_gated(cpu_clock_gated),
        .power_mode(power_mode), .sleep_wake(sleep_wake), .erase_busy(erase_busy),
        .debugger_lockout(debugger_lockout), .xosc_stable(xosc_stable),
        .hfrc_stable(hfrc_stable), .data_wr(data_wr), .data_wr_addr(data_wr_addr),
        .inject_opcode(inject_opcode), .step_branch(step_branch),
        .debug_active(debug_active), .timer_run_q(timer_run_q), .dma_hold_q(dma_hold_q),
        .info_region_select(info_region_select), .cpu_halt_q(cpu_halt_q),
        .regulator_hold_q(regulator_hold_q));

    // ======================================================================
    // checking and bus helpers
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] flags_exp();
        return {~erase_busy, cpu_clock_gated, halted_m, power_mode == 2'h0, cause_m,
                debugger_lockout, xosc_stable & hfrc_stable, ovf_m};
    endfunction

    task automatic run(input logic [7:0] op, input int n, input logic [23:0] d);
        logic [7:0] x;
        host.cmd(op, n, d, 1'b0, x);
    endtask

    task automatic rd_flags();
        host.cmd(dbgcs_pkg::OP_RD_FLAGS, 0, 24'h0, 1'b1, r);
        chk(r, flags_exp());
    endtask

    task automatic resume();
        run(dbgcs_pkg::OP_RESUME, 0, 24'h0);
        halted_m = 0;
        chk(cpu_halt_q, 1'b0);
    endtask

    task automatic set_trap(input int s, input logic en, input logic [17:0] a);
        run(dbgcs_pkg::OP_SET_TRAP, 3, {3'h0, s[1:0], en, a});
        tr_a[s] = a;
        tr_e[s] = en;
    endtask

    // park the code bus on an address and see whether the cpu stops
    task automatic probe(input logic [17:0] a);
        logic hit;
        hit = 0;
        for (int s = 0; s < 4; s++) hit |= tr_e[s] && tr_a[s] == a;
        @(negedge core_clk);
        cpu_code_addr = a;
        repeat (6) @(negedge core_clk);
        chk(cpu_halt_q, hit);
        cpu_code_addr = 18'h0;
        if (hit) begin
            halted_m = 1;
            cause_m  = 1;
            rd_flags();
            resume();
        end
    endtask

    // one-cycle strobe on a cpu side event: 0 data write, 1 sleep wake
    task automatic pulse(input int which);
        @(negedge core_clk);
        if (which == 0) data_wr = 1'b1;
        else sleep_wake = 1'b1;
        @(negedge core_clk);
        data_wr    = 1'b0;
        sleep_wake = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask

    // ======================================================================
    // scenarios
    initial begin
        repeat (8) @(negedge core_clk);
        repeat (4) @(posedge link_clk); // link side sees reset through two stages
        @(negedge core_clk);
        rst = 1'b0;
        chk({timer_run_q, dma_hold_q, info_region_select, cpu_halt_q, regulator_hold_q},
            18'h10);
        repeat (3) @(posedge link_clk);
        for (i = 0; i < 16; i++) begin
            run(dbgcs_pkg::OP_WR_SETTINGS, 1, {4'h0, i[3:0], 16'h0});
            set_m = i[3:0];
            host.cmd(dbgcs_pkg::OP_RD_SETTINGS, 0, 24'h0, 1'b1, r);
            chk(r, {4'h0, set_m});
            chk(dma_hold_q, set_m[2]);
            chk(info_region_select, set_m[0]);
            for (j = 0; j < 4; j++) begin
                @(negedge core_clk);
                {inject_opcode, step_branch} = j[1:0];
                repeat (3) @(negedge core_clk);
                chk(timer_run_q, !set_m[3] && !(set_m[1] && j != 0));
            end
        end
        for (i = 0; i < 12; i++) begin
            @(negedge core_clk);
            rv = $random(seed);
            {erase_busy, cpu_clock_gated, debugger_lockout, xosc_stable, hfrc_stable} = rv[4:0];
            power_mode = rv[6:5];
            rd_flags();
        end
        resume(); // resume while running changes nothing
        run(dbgcs_pkg::OP_HALT, 0, 24'h0);
        halted_m = 1;
        cause_m  = 0;
        chk(cpu_halt_q, 1'b1);
        // one-byte injected opcode; the framer must stay in step after it
        run({dbgcs_pkg::OP_INJECT_HI, 2'h1}, 1, 24'ha50000);
        rd_flags();
        resume();
        for (i = 0; i < 4; i++) begin
            rv = $random(seed);
            set_trap(i, 1'b1, rv[17:0] | 18'h20000);
        end
        for (i = 0; i < 4; i++) probe(tr_a[i]);
        set_trap(1, 1'b0, tr_a[1]);
        for (i = 0; i < 4; i++) probe(tr_a[i]);
        probe(tr_a[2] ^ 18'h1);
        @(negedge core_clk);
        data_wr_addr = 8'hfe;
        pulse(0);
        rd_flags();
        @(negedge core_clk);
        data_wr_addr = dbgcs_pkg::STACK_TOP_ADDR;
        pulse(0);
        ovf_m = 1;
        rd_flags();
        @(negedge core_clk);
        debug_active = 1;
        power_mode = 2'h1;
        pulse(1);
        chk({regulator_hold_q, cpu_halt_q}, 18'h2);
        power_mode = 2'h2;
        pulse(1);
        chk(cpu_halt_q, 1'b1);
        run(dbgcs_pkg::OP_HALT, 0, 24'h0);
        cause_m = 0;
        resume();
        close_out();
    end

    initial begin
        #3000000;
        bad_count++;
        close_out();
    end
endmodule
